// file: verilog/adc_calibration_control.sv
`timescale 1ns/1ns
`default_nettype none
`include "adc_cal_regs.svh"

module adc_calibration_control #(
    parameter int RESULT_WIDTH = 12
) (
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    // Special function register bus
    input  wire adc_cal_pkg::sfr_req_type sfrReq,
    output logic [7:0]                    sfrRdata,
    // Timing configuration from software
    input  wire logic [1:0]               acqTimeSel,
    input  wire logic [1:0]               clkDivSel,
    // Analog front end
    input  wire logic                     compIn,
    output logic [RESULT_WIDTH-1:0]       dacCode,
    output logic                          sampleTrack,
    output logic                          calActive,
    output logic                          calFullScale,
    output logic [3:0]                    chanSel,
    // Results
    output logic [RESULT_WIDTH-1:0]       result,
    output logic                          resultValid,
    output logic [RESULT_WIDTH+5:0]       calOffset,
    output logic [RESULT_WIDTH+5:0]       calGain
);
    localparam int AW = RESULT_WIDTH + 6;

    if (RESULT_WIDTH < 2 || RESULT_WIDTH > 14) begin : g_check
        $error("RESULT_WIDTH must fit inside the conversion phase");
    end

    function automatic logic [5:0] avgCount(input logic [1:0] sel);
        case (sel)
            2'b00:   avgCount = `ADC_AVG_CODE00;
            2'b01:   avgCount = `ADC_AVG_CODE01;
            2'b10:   avgCount = `ADC_AVG_CODE10;
            default: avgCount = `ADC_AVG_CODE11;
        endcase
    endfunction

    adc_cal_pkg::adc_state_type stateQ, stateD;
    logic [6:1]              ctlQ, ctlD;
    logic                    startQ, startD, sconvQ, sconvD, busyQ, busyD;
    logic [3:0]              chanQ, chanD, cntQ, cntD;
    logic [2:0]              divQ, divD;
    logic [5:0]              nQ, nD;
    logic [RESULT_WIDTH-1:0] sarQ, sarD, resQ, resD;
    logic [AW-1:0]           accQ, accD, offQ, offD, gainQ, gainD;
    logic                    validQ, validD, calQ, calD, typeQ, typeD, trackQ, trackD;
    logic [7:0]              rdQ, rdD;
    logic                    tick, wrCal, wrChan;
    logic [2:0]              divMax;

    // Converter clock is a divided tick so all state stays in one domain
    assign divMax = 3'((4'h1 << clkDivSel) - 4'h1);
    assign tick   = (divQ >= divMax);
    assign wrCal  = sfrReq.write && sfrReq.addr == `ADC_CAL_CONTROL_ADDR;
    assign wrChan = sfrReq.write && sfrReq.addr == `ADC_CHANNEL_CONTROL_ADDR;

    always_comb begin
        int idx;
        idx    = 0;
        stateD = stateQ;
        ctlD   = ctlQ;
        startD = startQ;
        sconvD = sconvQ;
        chanD  = chanQ;
        cntD   = cntQ;
        divD   = tick ? 3'h0 : divQ + 3'h1;
        nD     = nQ;
        sarD   = sarQ;
        resD   = resQ;
        accD   = accQ;
        offD   = offQ;
        gainD  = gainQ;
        validD = 1'b0;
        calD   = calQ;
        typeD  = typeQ;
        // Bit 7 is not stored; averaging is frozen while a calibration runs
        if (wrCal) begin
            ctlD = calQ ? {sfrReq.wdata[6], ctlQ[5:4], sfrReq.wdata[3:1]} : sfrReq.wdata[6:1];
            if (!busyQ) begin
                startD = sfrReq.wdata[`ADC_CAL_START_BIT];
            end
        end
        if (wrChan) begin
            chanD = sfrReq.wdata[3:0];
            if (!busyQ) begin
                sconvD = sfrReq.wdata[`ADC_SINGLE_CONVERT_BIT];
            end
        end
        case (stateQ)
            adc_cal_pkg::S_IDLE: begin
                if (startQ) begin
                    if (ctlQ[`ADC_CAL_TYPE_BIT] && ctlQ[`ADC_GAIN_CAL_DISABLE_BIT]) begin
                        startD = 1'b0;
                    end else begin
                        stateD = adc_cal_pkg::S_SYNC;
                        calD   = 1'b1;
                        typeD  = ctlQ[`ADC_CAL_TYPE_BIT];
                        nD     = 6'h0;
                        accD   = '0;
                        cntD   = 4'h0;
                        divD   = 3'h0;
                    end
                end else if (sconvQ) begin
                    stateD = adc_cal_pkg::S_SYNC;
                    calD   = 1'b0;
                    cntD   = 4'h0;
                    divD   = 3'h0;
                end
            end
            adc_cal_pkg::S_SYNC: begin
                if (tick) begin
                    cntD = cntQ + 4'h1;
                    if (cntQ + 4'h1 >= `ADC_SYNC_CLKS) begin
                        stateD = adc_cal_pkg::S_TRACK;
                        cntD   = 4'h0;
                    end
                end
            end
            adc_cal_pkg::S_TRACK: begin
                if (tick) begin
                    cntD = cntQ + 4'h1;
                    if (cntQ >= {2'b00, acqTimeSel}) begin
                        stateD = adc_cal_pkg::S_CONVERT;
                        cntD   = 4'h0;
                        sarD   = '0;
                        sarD[RESULT_WIDTH-1] = 1'b1;
                    end
                end
            end
            adc_cal_pkg::S_CONVERT: begin
                if (tick) begin
                    cntD = cntQ + 4'h1;
                    if (int'(cntQ) < RESULT_WIDTH) begin
                        idx = RESULT_WIDTH - 1 - int'(cntQ);
                        sarD[idx] = compIn;
                        if (idx != 0) begin
                            sarD[idx-1] = 1'b1;
                        end
                    end
                    if (cntQ + 4'h1 >= `ADC_CONV_CLKS) begin
                        stateD = adc_cal_pkg::S_DONE;
                        resD   = sarQ;
                        validD = !calQ;
                    end
                end
            end
            adc_cal_pkg::S_DONE: begin
                cntD = 4'h0;
                divD = 3'h0;
                if (!calQ) begin
                    stateD = adc_cal_pkg::S_IDLE;
                    sconvD = 1'b0;
                end else begin
                    accD = accQ + AW'(resQ);
                    nD   = nQ + 6'h1;
                    if (nQ + 6'h1 >= avgCount(ctlQ[`ADC_AVG_SEL_HI_BIT:`ADC_AVG_SEL_LO_BIT])) begin
                        stateD = adc_cal_pkg::S_IDLE;
                        startD = 1'b0;
                        calD   = 1'b0;
                        if (typeQ) begin
                            gainD = accQ + AW'(resQ);
                        end else begin
                            offD = accQ + AW'(resQ);
                        end
                    end else begin
                        stateD = adc_cal_pkg::S_SYNC;
                    end
                end
            end
            default: stateD = adc_cal_pkg::S_IDLE;
        endcase
        busyD  = stateD != adc_cal_pkg::S_IDLE;
        trackD = stateD == adc_cal_pkg::S_TRACK;
        rdD    = rdQ;
        if (sfrReq.read) begin
            if (sfrReq.addr == `ADC_CAL_CONTROL_ADDR) begin
                rdD = {busyQ, ctlQ, startQ};
            end else if (sfrReq.addr == `ADC_CHANNEL_CONTROL_ADDR) begin
                rdD = {3'b000, sconvQ, chanQ};
            end else begin
                rdD = 8'h00;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stateQ <= adc_cal_pkg::S_IDLE;
            ctlQ   <= 6'h00;
            startQ <= 1'b0;
            sconvQ <= 1'b0;
            busyQ  <= 1'b0;
            chanQ  <= 4'h0;
            cntQ   <= 4'h0;
            divQ   <= 3'h0;
            nQ     <= 6'h00;
            sarQ   <= '0;
            resQ   <= '0;
            accQ   <= '0;
            offQ   <= '0;
            gainQ  <= '0;
            validQ <= 1'b0;
            calQ   <= 1'b0;
            typeQ  <= 1'b0;
            trackQ <= 1'b0;
            rdQ    <= 8'h00;
        end else begin
            stateQ <= stateD;
            ctlQ   <= ctlD;
            startQ <= startD;
            sconvQ <= sconvD;
            busyQ  <= busyD;
            chanQ  <= chanD;
            cntQ   <= cntD;
            divQ   <= divD;
            nQ     <= nD;
            sarQ   <= sarD;
            resQ   <= resD;
            accQ   <= accD;
            offQ   <= offD;
            gainQ  <= gainD;
            validQ <= validD;
            calQ   <= calD;
            typeQ  <= typeD;
            trackQ <= trackD;
            rdQ    <= rdD;
        end
    end

    assign sfrRdata     = rdQ;
    assign dacCode      = sarQ;
    assign sampleTrack  = trackQ;
    assign calActive    = calQ;
    assign calFullScale = typeQ;
    assign chanSel      = chanQ;
    assign result       = resQ;
    assign resultValid  = validQ;
    assign calOffset    = offQ;
    assign calGain      = gainQ;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_busy_tracks_state: assert property (busyQ == (stateQ != adc_cal_pkg::S_IDLE))
        else $error("busy does not match sequencer");
    a_busy_write_ignored: assert property (stateQ == adc_cal_pkg::S_IDLE && !startQ && !sconvQ && wrCal
        && !sfrReq.wdata[0] && !wrChan |=> !busyQ)
        else $error("busy set by a write");
    a_busy_clears_end: assert property (stateQ == adc_cal_pkg::S_DONE && stateD == adc_cal_pkg::S_IDLE |=> !busyQ)
        else $error("busy stuck after end");
    a_gain_suppressed: assert property (stateQ == adc_cal_pkg::S_IDLE && startQ && ctlQ[6] && ctlQ[1]
        |=> !startQ && !busyQ)
        else $error("suppressed gain calibration ran");
    a_avg_count_end: assert property (stateQ == adc_cal_pkg::S_DONE && calQ && stateD == adc_cal_pkg::S_IDLE
        |-> nQ + 6'h1 == avgCount(ctlQ[5:4]))
        else $error("wrong number of averaged readings");
    a_cal_type_store: assert property (stateQ == adc_cal_pkg::S_DONE && calQ && stateD == adc_cal_pkg::S_IDLE
        && !typeQ |=> offQ == $past(accQ) + AW'($past(resQ)) && $stable(gainQ))
        else $error("offset calibration stored wrongly");
    a_start_begins: assert property (stateQ == adc_cal_pkg::S_IDLE && startQ && !(ctlQ[6] && ctlQ[1])
        |=> stateQ == adc_cal_pkg::S_SYNC && calQ && typeQ == $past(ctlQ[1]))
        else $error("calibration did not begin");
    a_start_cleared: assert property (stateQ == adc_cal_pkg::S_DONE && calQ && stateD == adc_cal_pkg::S_IDLE
        |=> !startQ)
        else $error("start bit not cleared");
    a_track_phase: assert property (sampleTrack == (stateQ == adc_cal_pkg::S_TRACK))
        else $error("track output out of phase");
    a_result_latch: assert property (stateQ == adc_cal_pkg::S_CONVERT && stateD == adc_cal_pkg::S_DONE
        |=> resQ == $past(sarQ) && validQ == !$past(calQ))
        else $error("result not latched");
    a_single_convert_request_cleared: assert property (stateQ == adc_cal_pkg::S_DONE && !calQ |=> !sconvQ && !busyQ)
        else $error("single request not cleared");
    a_busy_no_restart: assert property (busyQ && stateQ != adc_cal_pkg::S_DONE && wrCal |=> $stable(startQ))
        else $error("start accepted while busy");

    c_single_conv: cover property (stateQ == adc_cal_pkg::S_DONE && !calQ);
    c_offset_cal: cover property (stateQ == adc_cal_pkg::S_DONE && calQ && !typeQ && stateD == adc_cal_pkg::S_IDLE);
    c_gain_cal: cover property (stateQ == adc_cal_pkg::S_DONE && calQ && typeQ && stateD == adc_cal_pkg::S_IDLE);
    c_busy_write: cover property (busyQ && wrCal && sfrReq.wdata[0]);
endmodule
`default_nettype wire

// file: include/adc_cal_regs.svh
`ifndef ADC_CAL_REGS_SVH
`define ADC_CAL_REGS_SVH
// Register addresses and reset values on the special function bus
`define ADC_CAL_CONTROL_ADDR      8'hf5
`define ADC_CHANNEL_CONTROL_ADDR  8'hd8
`define ADC_CAL_CONTROL_RESET     8'h00
`define ADC_CHANNEL_CONTROL_RESET 8'h00
// Field positions in adc_cal_control
`define ADC_BUSY_BIT              7
`define ADC_GAIN_CAL_DISABLE_BIT  6
`define ADC_AVG_SEL_HI_BIT        5
`define ADC_AVG_SEL_LO_BIT        4
`define ADC_CAL_TYPE_BIT          1
`define ADC_CAL_START_BIT         0
// Field positions in adc_channel_control
`define ADC_SINGLE_CONVERT_BIT    4
// Averaging counts per selector code
`define ADC_AVG_CODE00            6'h0f
`define ADC_AVG_CODE01            6'h01
`define ADC_AVG_CODE10            6'h1f
`define ADC_AVG_CODE11            6'h3f
// Phase lengths in converter clocks
`define ADC_SYNC_CLKS             4'h1
`define ADC_CONV_CLKS             4'hf
`endif

// file: include/adc_cal_pkg.sv
`default_nettype none
package adc_cal_pkg;
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_type;

    typedef enum logic [2:0] {
        S_IDLE,
        S_SYNC,
        S_TRACK,
        S_CONVERT,
        S_DONE
    } adc_state_type;
endpackage
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "adc_cal_regs.svh"

module tb_top;
    logic                     clk;
    logic                     reset_n;
    adc_cal_pkg::sfr_req_type sfrReq;
    logic [7:0]               sfrRdata;
    logic [1:0]               acqTimeSel;
    logic [1:0]               clkDivSel;
    logic                     compIn;
    logic [11:0]              dacCode;
    logic                     sampleTrack;
    logic                     calActive;
    logic                     calFullScale;
    logic [3:0]               chanSel;
    logic [11:0]              result;
    logic                     resultValid;
    logic [17:0]              calOffset;
    logic [17:0]              calGain;
    logic [11:0]              vin;
    logic                     trackPrev;
    logic                     trackAtDone;
    logic                     sawFull;
    logic [7:0]               rd;
    logic                     wasBusy;
    int                       calReads;
    int                       trackLen;
    int                       validCount;
    int                       cycles;
    int                       bad_count;
    int                       checks;
    int                       avgTab [4] = '{15, 1, 31, 63};

    adc_calibration_control #(.RESULT_WIDTH(12)) dut_u (
        .clk(clk), .reset_n(reset_n), .sfrReq(sfrReq), .sfrRdata(sfrRdata),
        .acqTimeSel(acqTimeSel), .clkDivSel(clkDivSel), .compIn(compIn),
        .dacCode(dacCode), .sampleTrack(sampleTrack), .calActive(calActive),
        .calFullScale(calFullScale), .chanSel(chanSel), .result(result),
        .resultValid(resultValid), .calOffset(calOffset), .calGain(calGain)
    );

    always #2 clk = ~clk;

    // Comparator lags dacCode by one clock, so runs use a divide of at least two
    always @(posedge clk) begin
        compIn <= (vin >= dacCode);
    end

    always @(posedge clk) begin
        if (sampleTrack === 1'b1 && trackPrev === 1'b0 && calActive === 1'b1) calReads++;
        if (sampleTrack === 1'b1) trackLen++;
        trackPrev = sampleTrack;
        if (resultValid === 1'b1) begin
            validCount++;
            trackAtDone = sampleTrack;
        end
        if (calActive === 1'b1 && calFullScale === 1'b1) sawFull = 1'b1;
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        checks++;
        if (seen !== expected) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expected);
        end
    endtask

    task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfrReq <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        sfrReq <= '0;
    endtask

    task automatic regRead(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        sfrReq <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        sfrReq <= '0;
        @(negedge clk);
        d = sfrRdata;
    endtask

    // Busy only shows two clocks after the request edge, so poll after a gap
    task automatic waitIdle(output logic firstBusy);
        logic [7:0] v;
        repeat (4) @(posedge clk);
        regRead(`ADC_CAL_CONTROL_ADDR, v);
        firstBusy = v[7];
        for (int i = 0; i < 3000 && v[7] !== 1'b0; i++) regRead(`ADC_CAL_CONTROL_ADDR, v);
        check(v[7], 1'b0);
    endtask

    task automatic wrap_up();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        sfrReq = '0;
        acqTimeSel = 2'h1;
        clkDivSel = 2'h1;
        compIn = 1'b0;
        vin = 12'h5a3;
        trackPrev = 1'b0;
        trackAtDone = 1'b1;
        sawFull = 1'b0;
        calReads = 0;
        validCount = 0;
        trackLen = 0;
        cycles = 0;
        bad_count = 0;
        checks = 0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        regRead(`ADC_CAL_CONTROL_ADDR, rd);
        check(rd, `ADC_CAL_CONTROL_RESET);
        regRead(`ADC_CHANNEL_CONTROL_ADDR, rd);
        check(rd, `ADC_CHANNEL_CONTROL_RESET);
        // Busy is not writable, the other stored bits read back
        regWrite(`ADC_CAL_CONTROL_ADDR, 8'hf4);
        regRead(`ADC_CAL_CONTROL_ADDR, rd);
        check(rd, 8'h74);
        regRead(8'h00, rd);
        check(rd, 8'h00);
        regWrite(`ADC_CHANNEL_CONTROL_ADDR, 8'he3);
        regRead(`ADC_CHANNEL_CONTROL_ADDR, rd);
        check(rd, 8'h03);
        check(chanSel, 4'h3);
        // Single conversion
        regWrite(`ADC_CHANNEL_CONTROL_ADDR, 8'h15);
        waitIdle(wasBusy);
        check(wasBusy, 1'b1);
        check(validCount, 1);
        check(result, vin);
        check(trackAtDone, 1'b0);
        regRead(`ADC_CHANNEL_CONTROL_ADDR, rd);
        check(rd, 8'h05);
        check(calReads, 0);
        check(trackLen, 4);
        // Every averaging code with an offset calibration
        for (int k = 0; k < 4; k++) begin
            calReads = 0;
            regWrite(`ADC_CAL_CONTROL_ADDR, 8'h05 | (8'(k) << 4));
            waitIdle(wasBusy);
            check(wasBusy, 1'b1);
            check(calReads, avgTab[k]);
            check(calOffset, 18'(avgTab[k]) * 18'(vin));
            regRead(`ADC_CAL_CONTROL_ADDR, rd);
            check(rd, 8'h04 | (8'(k) << 4));
        end
        check(validCount, 1);
        check(sawFull, 1'b0);
        // Gain calibration, then with gain disabled
        calReads = 0;
        regWrite(`ADC_CAL_CONTROL_ADDR, 8'h17);
        waitIdle(wasBusy);
        check(calGain, 18'(vin));
        check(sawFull, 1'b1);
        regRead(`ADC_CAL_CONTROL_ADDR, rd);
        check(rd, 8'h16);
        vin = 12'h0a1;
        calReads = 0;
        regWrite(`ADC_CAL_CONTROL_ADDR, 8'h57);
        waitIdle(wasBusy);
        check(calReads, 0);
        check(calGain, 18'h005a3);
        regRead(`ADC_CAL_CONTROL_ADDR, rd);
        check(rd, 8'h56);
        // Start of a calibration while a conversion runs
        regWrite(`ADC_CHANNEL_CONTROL_ADDR, 8'h10);
        repeat (4) @(posedge clk);
        regWrite(`ADC_CAL_CONTROL_ADDR, 8'h05);
        waitIdle(wasBusy);
        check(calReads, 0);
        check(validCount, 2);
        check(result, vin);
        regRead(`ADC_CAL_CONTROL_ADDR, rd);
        check(rd, 8'h04);
        // Conversion request during a long calibration
        regWrite(`ADC_CAL_CONTROL_ADDR, 8'h35);
        repeat (4) @(posedge clk);
        regWrite(`ADC_CHANNEL_CONTROL_ADDR, 8'h10);
        regWrite(`ADC_CAL_CONTROL_ADDR, 8'h15);
        waitIdle(wasBusy);
        check(validCount, 2);
        check(calReads, 63);
        check(calOffset, 18'(63) * 18'(vin));
        regRead(`ADC_CHANNEL_CONTROL_ADDR, rd);
        check(rd, 8'h00);
        regRead(`ADC_CAL_CONTROL_ADDR, rd);
        check(rd, 8'h34);
        // Slower converter clock and longest acquisition
        trackLen = 0;
        @(posedge clk);
        acqTimeSel <= 2'h3;
        clkDivSel <= 2'h2;
        regWrite(`ADC_CHANNEL_CONTROL_ADDR, 8'h10);
        waitIdle(wasBusy);
        check(validCount, 3);
        check(result, vin);
        check(trackLen, 16);
        wrap_up();
    end
endmodule
`default_nettype wire
